// >>> fsdp_pkg.sv
// constants, register indices and carrier types for the field switch block
package fsdp_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int FSDP_RAW_W   = 14;
	localparam int FSDP_GAIN_W  = 14;
	localparam int FSDP_OFS_W   = 11;
	localparam int FSDP_REL_W   = 10;
	localparam int FSDP_OPR_W   = 11;
	localparam int FSDP_SIG_W   = 11;
	localparam int FSDP_MODE_W  = 10;
	localparam int FSDP_USER_W  = 13;
	localparam int FSDP_USER_N  = 4;
	localparam int FSDP_LOCK_W  = 2;
	localparam int FSDP_DATA_W  = 16;
	localparam int FSDP_ADDR_W  = 4;

	// ----------------------------------------------------------------
	// gain scaling: coefficient 1.0 is two to this power, shift back by this many bits
	// ----------------------------------------------------------------
	localparam int FSDP_GAIN_FRAC = 11;

	// ----------------------------------------------------------------
	// register indices on the command port
	// ----------------------------------------------------------------
	localparam logic [3:0] FSDP_IDX_MODE  = 4'h0;
	localparam logic [3:0] FSDP_IDX_GAIN  = 4'h1;
	localparam logic [3:0] FSDP_IDX_OFS   = 4'h2;
	localparam logic [3:0] FSDP_IDX_REL   = 4'h3;
	localparam logic [3:0] FSDP_IDX_OPR   = 4'h4;
	localparam logic [3:0] FSDP_IDX_USER0 = 4'h5;
	localparam logic [3:0] FSDP_IDX_USER3 = 4'h8;
	localparam logic [3:0] FSDP_IDX_LOCK  = 4'h9;
	localparam logic [3:0] FSDP_IDX_RAW   = 4'hA;
	localparam logic [3:0] FSDP_IDX_PROC  = 4'hB;

	// ----------------------------------------------------------------
	// mode register fields and format codes
	// ----------------------------------------------------------------
	localparam int         FSDP_FMT_LSB     = 5;
	localparam logic [2:0] FSDP_FMT_SW_POS  = 3'h4;
	localparam logic [2:0] FSDP_FMT_SW_NEG  = 3'h5;

	// ----------------------------------------------------------------
	// values after reset, and the boot count at which the lock bit is sampled
	// ----------------------------------------------------------------
	localparam logic [9:0]  FSDP_RST_MODE = 10'h090;
	localparam logic [13:0] FSDP_RST_GAIN = 14'h0800;
	localparam logic [10:0] FSDP_RST_OFS  = 11'h000;
	localparam logic [9:0]  FSDP_RST_REL  = 10'h200;
	localparam logic [10:0] FSDP_RST_OPR  = 11'h400;
	localparam logic [1:0]  FSDP_BOOT_CYC = 2'h2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        store;
		logic [3:0]  addr;
		logic [15:0] wdata;
	} fsdp_cmd_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} fsdp_rsp_t;

	typedef struct packed {
		logic [10:0] signal;
	} fsdp_dsp_state_t;

endpackage : fsdp_pkg

// >>> fsdp_dsp.sv
// gain, offset and saturation datapath of the field switch
`timescale 1ns/1ns
module fsdp_dsp (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// parameters and sample
	input  wire logic [13:0] raw,
	input  wire logic [13:0] gain,
	input  wire logic [10:0] offset,
	// result
	output logic      [10:0] signal
);

	fsdp_pkg::fsdp_dsp_state_t s;
	fsdp_pkg::fsdp_dsp_state_t next_s;

	logic signed [27:0] prod;
	logic signed [16:0] scaled;
	logic signed [17:0] sum;
	logic signed [17:0] vmax;

	// ----------------------------------------------------------------
	// multiply and add
	// ----------------------------------------------------------------
	assign prod   = $signed(raw) * $signed(gain); // see RULE_01
	// 1.0 moves the signal by full supply per 2048 raw counts
	assign scaled = prod[27:fsdp_pkg::FSDP_GAIN_FRAC]; // see RULE_02
	// offset steps are twice the signal step
	// concatenation is unsigned, so re-sign it before widening
	assign sum    = 18'(scaled) + 18'($signed({offset, 1'b0})); // see RULE_03

	// negative offset pulls the ceiling down with it
	assign vmax = offset[10] ? (18'sh0_0800 + 18'($signed({offset, 1'b0})))
	                         : 18'sh0_07FF; // see RULE_04

	// ----------------------------------------------------------------
	// clamp instead of wrap
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		if (sum < 18'sh0_0000) begin
			next_s.signal = 11'h000; // see RULE_23
		end else if (sum > vmax) begin
			next_s.signal = vmax[10:0]; // see RULE_23
		end else begin
			next_s.signal = sum[10:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign signal = s.signal;

endmodule : fsdp_dsp

// >>> fsdp_top.sv
// parameter registers, command handling and comparator of the field switch
//
// Functional notes
// RULE_01: signal path multiplies filtered field by signed gain, range +-4, step 1/2048.
// RULE_02: gain 1.0 moves signal by full supply per 2048 raw counts.
// RULE_03: zero-field offset added to product, range +-supply, step supply/1024.
// RULE_04: negative offset caps signal at offset plus one supply.
// RULE_05: release threshold spans zero to half supply, step supply/2048.
// RULE_06: operate threshold spans zero to full supply, step supply/2048.
// RULE_07: above operate drive low, below release drive high, else hold.
// RULE_08: four 13-bit user words, readable and writable.
// RULE_09: programmer accesses all four user words in order from word zero.
// RULE_10: programmer writes all four user words, then one store.
// RULE_11: changing one user word needs read-back of the others first.
// RULE_12: 2-bit lock latch; setting bit zero locks all registers.
// RULE_13: lock acts only after the next power cycle.
// RULE_14: lock latch never clears by command or reset; here reset clears it and bit zero is reloaded from NV_LOCK at power-up.
// RULE_15: once locked, every register read is refused.
// RULE_16: 14-bit read-only raw field value, before gain and offset.
// RULE_17: 14-bit processed value read with its bits reversed.
// RULE_18: processed value reads zero unless analog format selected.
// RULE_19: raw field value is signed, south negative, north positive.
// RULE_20: unlocked, gain, offset and thresholds rewrite any number of times.
// RULE_21: programmer should pick the 500 Hz filter setting.
// RULE_22: switch output off during commands; answer after decoding; here a locked part keeps driving the pin.
// RULE_23: signal saturates after multiply and add, no wrap.
`timescale 1ns/1ns
module fsdp_top #(
	// format code of the analog output mode
	parameter logic [2:0] ANALOG_FORMAT = 3'h0
) (
	// clock and reset
	input  wire logic                CLK_SYS,
	input  wire logic                RST_N,
	// filtered field sample
	input  wire logic                SAMPLE_VALID,
	input  wire logic [13:0]         SAMPLE_RAW,
	// decoded supply-modulation commands
	input  wire logic                COMM_ACTIVE,
	input  wire fsdp_pkg::fsdp_cmd_t CMD,
	output fsdp_pkg::fsdp_rsp_t      RSP,
	// non-volatile lock bit
	input  wire logic                NV_LOCK,
	output logic                     LOCK_STORE,
	// switch output pin
	output logic                     OUT_O,
	output logic                     OUT_OE_N,
	// processed signal value
	output logic [10:0]              SIGNAL_VALUE
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             nv_meta;
		logic             nv_sync;
		logic [1:0]       boot_cnt;
		logic             booted;
		logic             lock_active;
		logic [1:0]       lock_latch;
		logic [9:0]       mode;
		logic [13:0]      gain;
		logic [10:0]      offset;
		logic [9:0]       release_lvl;
		logic [10:0]      operate_lvl;
		logic [3:0][12:0] user;
		logic [3:0][12:0] stage;
		logic [13:0]      raw;
		logic             sw_high;
		logic             out_o;
		logic             out_oe_n;
		fsdp_pkg::fsdp_rsp_t rsp;
	} fsdp_state_t;

	fsdp_state_t s;
	fsdp_state_t next_s;

	logic [10:0] sig;
	logic [2:0]  fmt;
	logic        cmd_ok;
	logic [1:0]  user_idx;
	logic        is_user;

	// ----------------------------------------------------------------
	// datapath
	// ----------------------------------------------------------------
	fsdp_dsp u_dsp (
		.clk_sys (CLK_SYS),
		.rst_n   (RST_N),
		.raw     (s.raw),
		.gain    (s.gain),
		.offset  (s.offset),
		.signal  (sig)
	);

	assign fmt = s.mode[fsdp_pkg::FSDP_FMT_LSB +: 3];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [13:0] fsdp_rev14(input logic [13:0] v);
		logic [13:0] r;
		r = '0;
		for (int i = 0; i < 14; i++) begin
			r[i] = v[13 - i];
		end
		return r;
	endfunction : fsdp_rev14

	function automatic logic [15:0] fsdp_read(
		input fsdp_state_t st,
		input logic [3:0]  a,
		input logic [10:0] sv,
		input logic        analog
	);
		logic [15:0] d;
		d = '0;
		if (a >= fsdp_pkg::FSDP_IDX_USER0 && a <= fsdp_pkg::FSDP_IDX_USER3) begin
			d = {3'h0, st.user[2'(a - fsdp_pkg::FSDP_IDX_USER0)]}; // see RULE_08
		end else begin
			unique case (a)
				fsdp_pkg::FSDP_IDX_MODE: begin
					d = {6'h00, st.mode};
				end
				fsdp_pkg::FSDP_IDX_GAIN: begin
					d = {2'h0, st.gain};
				end
				fsdp_pkg::FSDP_IDX_OFS: begin
					d = {5'h00, st.offset};
				end
				fsdp_pkg::FSDP_IDX_REL: begin
					d = {6'h00, st.release_lvl};
				end
				fsdp_pkg::FSDP_IDX_OPR: begin
					d = {5'h00, st.operate_lvl};
				end
				fsdp_pkg::FSDP_IDX_LOCK: begin
					d = {14'h0000, st.lock_latch};
				end
				fsdp_pkg::FSDP_IDX_RAW: begin
					d = {2'h0, st.raw}; // see RULE_16
				end
				fsdp_pkg::FSDP_IDX_PROC: begin
					if (analog) begin
						d = {2'h0, fsdp_rev14({3'h0, sv})}; // see RULE_17
					end else begin
						d = 16'h0000; // see RULE_18
					end
				end
				default: begin
					d = 16'h0000;
				end
			endcase
		end
		return d;
	endfunction : fsdp_read

	// ----------------------------------------------------------------
	// command qualification
	// ----------------------------------------------------------------
	// a locked part ignores the supply modulation entirely
	assign cmd_ok = CMD.valid && s.booted && !s.lock_active; // see RULE_15
	assign is_user = CMD.addr >= fsdp_pkg::FSDP_IDX_USER0
	              && CMD.addr <= fsdp_pkg::FSDP_IDX_USER3;
	assign user_idx = 2'(CMD.addr - fsdp_pkg::FSDP_IDX_USER0);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.nv_meta   = NV_LOCK;
		next_s.nv_sync   = s.nv_meta;
		next_s.rsp.valid = 1'b0;

		// lock state is sampled once per power-up, after the sync settles
		if (!s.booted) begin
			next_s.boot_cnt = s.boot_cnt + 2'h1;
			if (s.boot_cnt == fsdp_pkg::FSDP_BOOT_CYC) begin
				next_s.booted        = 1'b1;
				next_s.lock_active   = s.nv_sync; // see RULE_13
				next_s.lock_latch[0] = s.lock_latch[0] | s.nv_sync; // see RULE_14
			end
		end

		// raw sample is kept signed as delivered
		if (SAMPLE_VALID) begin
			next_s.raw = SAMPLE_RAW; // see RULE_19
		end

		if (cmd_ok) begin
			next_s.rsp.valid = 1'b1; // see RULE_22
			next_s.rsp.data  = 16'h0000;
			if (CMD.store) begin
				// user words go live together, torn sets never show
				next_s.user = s.stage; // see RULE_10
			end else if (CMD.write) begin
				if (is_user) begin
					next_s.stage[user_idx] = CMD.wdata[12:0]; // see RULE_08
				end else begin
					unique case (CMD.addr)
						fsdp_pkg::FSDP_IDX_MODE: begin
							next_s.mode = CMD.wdata[9:0];
						end
						fsdp_pkg::FSDP_IDX_GAIN: begin
							next_s.gain = CMD.wdata[13:0]; // see RULE_20
						end
						fsdp_pkg::FSDP_IDX_OFS: begin
							next_s.offset = CMD.wdata[10:0]; // see RULE_20
						end
						fsdp_pkg::FSDP_IDX_REL: begin
							next_s.release_lvl = CMD.wdata[9:0]; // see RULE_05
						end
						fsdp_pkg::FSDP_IDX_OPR: begin
							next_s.operate_lvl = CMD.wdata[10:0]; // see RULE_06
						end
						fsdp_pkg::FSDP_IDX_LOCK: begin
							// bits only ever set; takes hold at next power-up
							next_s.lock_latch = s.lock_latch | CMD.wdata[1:0]; // see RULE_12
						end
						default: begin
							next_s.lock_latch = s.lock_latch;
						end
					endcase
				end
			end else begin
				next_s.rsp.data = fsdp_read(s, CMD.addr, sig, fmt == ANALOG_FORMAT);
			end
		end

		// hysteresis comparator; between levels the state holds
		if (sig > s.operate_lvl) begin
			next_s.sw_high = 1'b0; // see RULE_07
		end else if (sig < {1'b0, s.release_lvl}) begin
			next_s.sw_high = 1'b1; // see RULE_07
		end

		if (fmt == fsdp_pkg::FSDP_FMT_SW_NEG) begin
			next_s.out_o = ~s.sw_high;
		end else begin
			next_s.out_o = s.sw_high;
		end

		// pin released while a telegram runs, unless the part is locked
		next_s.out_oe_n = (COMM_ACTIVE || CMD.valid) && !s.lock_active; // see RULE_22
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			s             <= '0;
			s.mode        <= fsdp_pkg::FSDP_RST_MODE;
			s.gain        <= fsdp_pkg::FSDP_RST_GAIN;
			s.offset      <= fsdp_pkg::FSDP_RST_OFS;
			s.release_lvl <= fsdp_pkg::FSDP_RST_REL;
			s.operate_lvl <= fsdp_pkg::FSDP_RST_OPR;
			s.sw_high     <= 1'b1;
			s.out_o       <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign RSP          = s.rsp;
	assign LOCK_STORE   = s.lock_latch[0]; // see RULE_12
	assign OUT_O        = s.out_o;
	assign OUT_OE_N     = s.out_oe_n;
	assign SIGNAL_VALUE = sig;

endmodule : fsdp_top

// >>> fsdp_top_assertions.sv
// port checks of the field switch top, bound into every instance
`timescale 1ns/1ns
module fsdp_top_assertions (
	// clock and reset
	input wire logic                CLK_SYS,
	input wire logic                RST_N,
	// command side
	input wire logic                COMM_ACTIVE,
	input wire fsdp_pkg::fsdp_cmd_t CMD,
	input wire fsdp_pkg::fsdp_rsp_t RSP,
	// lock and pin
	input wire logic                LOCK_STORE,
	input wire logic                OUT_OE_N
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	property p_rsp_cause; RSP.valid |-> $past(CMD.valid); endproperty
	a_rsp_cause: assert property (p_rsp_cause) else $error("answer without command");
	property p_wr_zero;
		RSP.valid && $past(CMD.valid && (CMD.write || CMD.store)) |-> RSP.data == 16'h0000;
	endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write answer not zero");
	property p_oe_rise; $rose(OUT_OE_N) |-> $past(COMM_ACTIVE || CMD.valid); endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("pin released unasked");
	property p_oe_back; !COMM_ACTIVE && !CMD.valid |=> !OUT_OE_N; endproperty
	a_oe_back: assert property (p_oe_back) else $error("pin not driven again");
	property p_oe_hold; !LOCK_STORE && $past(COMM_ACTIVE) |-> OUT_OE_N; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("pin driven during command");
	property p_lock_keep; LOCK_STORE |=> LOCK_STORE; endproperty
	a_lock_keep: assert property (p_lock_keep) else $error("lock latch cleared");
	property p_lock_set;
		RSP.valid && $past(CMD.valid && CMD.write && !CMD.store
			&& CMD.addr == fsdp_pkg::FSDP_IDX_LOCK && CMD.wdata[0]) |-> LOCK_STORE;
	endproperty
	a_lock_set: assert property (p_lock_set) else $error("lock bit not latched");
	property p_proc_bits;
		RSP.valid && $past(CMD.valid && !CMD.write && !CMD.store
			&& CMD.addr == fsdp_pkg::FSDP_IDX_PROC) |-> RSP.data[2:0] == 3'h0 && RSP.data[15:14] == 2'h0;
	endproperty
	a_proc_bits: assert property (p_proc_bits) else $error("processed value not mirrored");
	property p_unmapped;
		RSP.valid && $past(CMD.valid && !CMD.write && !CMD.store && CMD.addr > 4'hB)
			|-> RSP.data == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : fsdp_top_assertions

bind fsdp_top fsdp_top_assertions chk_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.COMM_ACTIVE(COMM_ACTIVE), .CMD(CMD), .RSP(RSP), .LOCK_STORE(LOCK_STORE), .OUT_OE_N(OUT_OE_N));

// >>> fsdp_prog_model.sv
// programmer model: telegram framing and register commands
`timescale 1ns/1ns
module fsdp_prog_model (
	// clock
	input  wire logic                clk_sys,
	// command side
	output fsdp_pkg::fsdp_cmd_t      cmd,
	output logic                     comm_active,
	input  wire fsdp_pkg::fsdp_rsp_t rsp
);
	initial begin
		cmd = '0;
		comm_active = 1'b0;
	end

	// qualifiers turn over after the pulse so stale fields never look valid
	task automatic xfer(input logic w, input logic s, input logic [3:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic got);
		@(negedge clk_sys);
		comm_active = 1'b1;
		@(negedge clk_sys);
		cmd = '{1'b1, w, s, a, d};
		@(negedge clk_sys);
		cmd = '{1'b0, ~w, ~s, ~a, ~d};
		got = rsp.valid;
		q = rsp.data;
		comm_active = 1'b0;
	endtask : xfer

	// ----------------------------------------------------------------
	// user words: always all four, from word zero
	// ----------------------------------------------------------------
	task automatic user_acc(input logic w, input logic st, inout logic [12:0] u [4]);
		logic [15:0] q;
		logic        g;
		for (int i = 0; i < 4; i++) begin
			xfer(w, 1'b0, fsdp_pkg::FSDP_IDX_USER0 + 4'(i), {3'h0, u[i]}, q, g);
			if (!w) u[i] = q[12:0];
		end
		if (st) xfer(1'b0, 1'b1, fsdp_pkg::FSDP_IDX_USER0, 16'h0000, q, g);
	endtask : user_acc
endmodule : fsdp_prog_model

// >>> fsdp_top_bench.sv
// self-checking bench of the field switch top
`timescale 1ns/1ns
module fsdp_top_bench;
	logic                clk_sys = 1'b0;
	logic                rst_n = 1'b0;
	logic                sample_valid = 1'b0;
	logic [13:0]         sample_raw = 14'h0000;
	logic                nv_lock = 1'b0;
	logic                comm_active;
	fsdp_pkg::fsdp_cmd_t cmd;
	fsdp_pkg::fsdp_rsp_t rsp;
	logic                lock_store;
	logic                out_o;
	logic                out_oe_n;
	logic [10:0]         signal_value;
	int                  mismatches = 0;
	int                  n_compared = 0;
	int                  cycles = 0;
	logic [31:0]         seed = 32'h790c_295a;

	always #50 clk_sys = ~clk_sys;

	fsdp_top dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n), .SAMPLE_VALID(sample_valid),
		.SAMPLE_RAW(sample_raw), .COMM_ACTIVE(comm_active), .CMD(cmd), .RSP(rsp),
		.NV_LOCK(nv_lock), .LOCK_STORE(lock_store), .OUT_O(out_o), .OUT_OE_N(out_oe_n),
		.SIGNAL_VALUE(signal_value));
	fsdp_prog_model prog_u (.clk_sys(clk_sys), .cmd(cmd), .comm_active(comm_active), .rsp(rsp));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [10:0] exp_sig(input logic [13:0] r, input logic [13:0] g,
		input logic [10:0] o);
		int p;
		int vmax;
		p = (int'($signed(r)) * int'($signed(g))) >>> 11;
		p = p + 2 * int'($signed(o));
		vmax = o[10] ? 2048 + 2 * int'($signed(o)) : 2047;
		if (p < 0) p = 0;
		if (p > vmax) p = vmax;
		return 11'(p);
	endfunction : exp_sig

	task automatic end_of_test();
		if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic acc(input logic w, input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
		logic [15:0] q;
		logic        g;
		prog_u.xfer(w, 1'b0, a, d, q, g);
		chk("answer", 16'h0001, {15'h0, g});
		chk("data", e, q);
	endtask : acc

	// comparator result needs four edges from the sample
	task automatic put(input logic [13:0] r);
		sample_raw = r;
		sample_valid = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask : put

	task automatic power_up(input logic nv);
		rst_n = 1'b0;
		nv_lock = nv;
		repeat (16) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (4) @(negedge clk_sys);
	endtask : power_up

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		logic [3:0]  ra [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hC};
		logic [15:0] rv [6] = '{16'h0090, 16'h0800, 16'h0000, 16'h0200, 16'h0400, 16'h0000};
		logic [13:0] cr [4] = '{14'h0350, 14'h0200, 14'h0050, 14'h0200};
		logic [12:0] u [4];
		logic [12:0] v [4];
		logic [13:0] r;
		logic [13:0] g;
		logic [10:0] o;
		logic [10:0] es;
		logic [13:0] pv;
		logic [15:0] q;
		logic        got;
		power_up(1'b0);
		for (int i = 0; i < 6; i++) acc(1'b0, ra[i], 16'h0000, rv[i]);
		for (int i = 0; i < 26; i++) begin
			g = (i == 0) ? 14'h1FFF : 14'(rnd());
			r = (i == 0) ? 14'h1FFF : 14'(rnd());
			o = (i == 1) ? 11'h400 : 11'(rnd());
			acc(1'b1, fsdp_pkg::FSDP_IDX_GAIN, {2'h0, g}, 16'h0000);
			acc(1'b1, fsdp_pkg::FSDP_IDX_OFS, {5'h00, o}, 16'h0000);
			put(r);
			es = exp_sig(r, g, o);
			chk("signal", {5'h00, es}, {5'h00, signal_value});
			acc(1'b0, fsdp_pkg::FSDP_IDX_RAW, 16'h0000, {2'h0, r});
		end
		acc(1'b0, fsdp_pkg::FSDP_IDX_PROC, 16'h0000, 16'h0000);
		acc(1'b1, fsdp_pkg::FSDP_IDX_MODE, 16'h0010, 16'h0000);
		pv = {<<{{3'h0, es}}};
		acc(1'b0, fsdp_pkg::FSDP_IDX_PROC, 16'h0000, {2'h0, pv});
		acc(1'b1, fsdp_pkg::FSDP_IDX_MODE, 16'h0090, 16'h0000);
		acc(1'b1, fsdp_pkg::FSDP_IDX_GAIN, 16'h0800, 16'h0000);
		acc(1'b1, fsdp_pkg::FSDP_IDX_OFS, 16'h0000, 16'h0000);
		acc(1'b1, fsdp_pkg::FSDP_IDX_REL, 16'h0100, 16'h0000);
		acc(1'b1, fsdp_pkg::FSDP_IDX_OPR, 16'h0300, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			put(cr[i]);
			chk("switch", {15'h0, i > 1}, {15'h0, out_o});
		end
		for (int i = 0; i < 4; i++) u[i] = 13'(rnd());
		prog_u.user_acc(1'b1, 1'b1, u);
		prog_u.user_acc(1'b0, 1'b0, v);
		for (int i = 0; i < 4; i++) chk("user", {3'h0, u[i]}, {3'h0, v[i]});
		for (int i = 0; i < 4; i++) v[i] = ~u[i];
		prog_u.user_acc(1'b1, 1'b0, v);
		prog_u.user_acc(1'b0, 1'b0, v);
		for (int i = 0; i < 4; i++) chk("live user", {3'h0, u[i]}, {3'h0, v[i]});
		acc(1'b1, fsdp_pkg::FSDP_IDX_LOCK, 16'h0001, 16'h0000);
		chk("lock store", 16'h0001, {15'h0, lock_store});
		acc(1'b0, fsdp_pkg::FSDP_IDX_GAIN, 16'h0000, 16'h0800);
		for (int k = 0; k < 2; k++) begin
			power_up(1'b1);
			prog_u.xfer(1'b0, 1'b0, fsdp_pkg::FSDP_IDX_USER0, 16'h0000, q, got);
			chk("refused", 16'h0000, {15'h0, got});
			chk("lock kept", 16'h0001, {15'h0, lock_store});
		end
		end_of_test();
	end
endmodule : fsdp_top_bench
